// ==== verilog/bytewide_port_pkg.sv ====
package bytewide_port_pkg;
   localparam int          ADDR_W      = 15;            // Address width
   localparam int          DATA_W      = 8;             // Data bus width
   localparam int          REG_CNT     = 16;            // Register bytes
   localparam int          ARRAY_BYTES = 32752;         // Storage bytes
   localparam logic [14:0] REG_BASE    = 15'h7ff0;      // First register
   localparam logic [7:0]  REG_RESET   = 8'h00;         // Register reset
   localparam int          SRC_CNT     = 3;             // Interrupt sources

   // Control pins from the host, as sampled
   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
   } ctl_s;

   // Idle level of the host strobes: all three pins high
   localparam ctl_s        CTL_IDLE    = 3'h7;          // Strobe reset

   // Interrupt source enables
   typedef struct packed {
      logic watchdog;
      logic alarm;
      logic power;
   } irq_src_s;
endpackage : bytewide_port_pkg

// ==== verilog/bytewide_memory_host_port.sv ====
`timescale 1ns/1ps
module bytewide_memory_host_port
(
   // Clock and reset
   input  wire logic                                clk_sys_in,
   input  wire logic                                rstn_in,
   // Host pins
   input  wire logic                                ce_n_in,
   input  wire logic                                we_n_in,
   input  wire logic                                oe_n_in,
   input  wire logic [bytewide_port_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [bytewide_port_pkg::DATA_W-1:0] dq_in,
   output logic      [bytewide_port_pkg::DATA_W-1:0] dq_out,
   output logic                                     dq_oe_out,
   // Interrupt configuration and events
   input  wire bytewide_port_pkg::irq_src_s         irq_en_in,
   input  wire bytewide_port_pkg::irq_src_s         irq_event_in,
   input  wire logic                                irq_high_in,
   // Interrupt pin, two-signal form
   output logic                                     irq_pin_out,
   output logic                                     irq_oe_out,
   // Status
   output logic                                     reg_sel_out
);

   // Synchroniser stages for the host strobes; reset parks them at the
   // idle level of the pins, so no false select edge follows reset
   bytewide_port_pkg::ctl_s              s1_q;       // Strobe stage one
   bytewide_port_pkg::ctl_s              s2_q;       // Strobe stage two
   bytewide_port_pkg::ctl_s              s3_q;       // Strobe stage three
   bytewide_port_pkg::ctl_s              ctl_q;      // Last agreed strobes
   bytewide_port_pkg::ctl_s              ctl_d;      // Strobes agreed now

   // Address and write data ride through matching stages, so the value
   // used always lines up with the strobe that qualifies it
   logic [bytewide_port_pkg::ADDR_W-1:0] a1_q;       // Address stage one
   logic [bytewide_port_pkg::ADDR_W-1:0] a2_q;       // Address stage two
   logic [bytewide_port_pkg::ADDR_W-1:0] a3_q;       // Address stage three
   logic [bytewide_port_pkg::DATA_W-1:0] d1_q;       // Data stage one
   logic [bytewide_port_pkg::DATA_W-1:0] d2_q;       // Data stage two
   logic [bytewide_port_pkg::DATA_W-1:0] d3_q;       // Data stage three

   // Port state: each register has its next value beside it
   logic [bytewide_port_pkg::ADDR_W-1:0] lat_q;      // Latched address
   logic [bytewide_port_pkg::ADDR_W-1:0] lat_d;      // Next latched address
   logic [bytewide_port_pkg::DATA_W-1:0] rd_q;       // Read data
   logic [bytewide_port_pkg::DATA_W-1:0] rd_d;       // Next read data
   logic                                 sel_q;      // Access open
   logic                                 sel_d;      // Next access open
   logic                                 reg_sel_q;  // Open on a register
   logic                                 reg_sel_d;  // Next register flag

   // Storage: the array spans the whole map so the top sixteen words
   // simply go unused; a little area is traded for a simpler decode
   logic [bytewide_port_pkg::DATA_W-1:0]
      mem_q [0:(1 << bytewide_port_pkg::ADDR_W)-1];  // Storage bytes
   logic [bytewide_port_pkg::DATA_W-1:0]
      regs_q [0:bytewide_port_pkg::REG_CNT-1];       // Register bytes

   // Decoded strobes from agreed synchroniser stages, plus the interrupt summary
   logic                                 ce_fall;    // Select seen falling
   logic                                 wr_en;      // Write under way
   logic                                 rd_en;      // Read under way
   logic                                 irq_any;    // Enabled source active

   // Register window decode, shared by read, write and status paths
   function automatic logic is_reg
   (
      input logic [bytewide_port_pkg::ADDR_W-1:0] a
   );
      is_reg = (a >= bytewide_port_pkg::REG_BASE);
   endfunction : is_reg

   // Byte index inside the register window
   function automatic logic [3:0] reg_idx
   (
      input logic [bytewide_port_pkg::ADDR_W-1:0] a
   );
      reg_idx = a[3:0];
   endfunction : reg_idx

   // Strobe synchroniser and agreed level; only stage two reads stage
   // one, so a metastable first stage never reaches the decode
   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
      begin
         s1_q  <= bytewide_port_pkg::CTL_IDLE;
         s2_q  <= bytewide_port_pkg::CTL_IDLE;
         s3_q  <= bytewide_port_pkg::CTL_IDLE;
         ctl_q <= bytewide_port_pkg::CTL_IDLE;
      end
      else
      begin
         s1_q  <= {ce_n_in, we_n_in, oe_n_in};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         ctl_q <= ctl_d;
      end
   end

   // Address and data stages carry no reset: they are only used once a
   // strobe has settled, and leaving them plain keeps them small
   always_ff @(posedge clk_sys_in)
   begin
      a1_q <= addr_in;
      a2_q <= a1_q;
      a3_q <= a2_q;
      d1_q <= dq_in;
      d2_q <= d1_q;
      d3_q <= d2_q;
   end

   // A strobe counts only once stages two and three agree; until then
   // the last agreed level stands, so a pin caught mid-change is held
   // off for one more cycle rather than read twice
   always_comb
   begin
      ctl_d = (s2_q & s3_q) | (ctl_q & (s2_q | s3_q));
   end

   // Access strobes; a write needs select and write enable low, a read
   // needs write enable high and output enable low as well
   always_comb
   begin
      ce_fall = ctl_q.ce_n && !ctl_d.ce_n;
      wr_en   = sel_q && !ctl_d.ce_n && !ctl_d.we_n;
      rd_en   = sel_q && !ctl_d.ce_n && ctl_d.we_n
                && !ctl_d.oe_n;
   end

   // Next state: latch the address on the select fall and hold it,
   // whatever the pins do, until the next fall
   always_comb
   begin
      lat_d = lat_q;
      sel_d = sel_q;
      if (ctl_d.ce_n)
         sel_d = 1'b0;
      else if (ce_fall)
      begin
         lat_d = a3_q;
         sel_d = 1'b1;
      end
      reg_sel_d = sel_d && is_reg(lat_d);
      if (is_reg(lat_q))
         rd_d = regs_q[reg_idx(lat_q)];
      else
         rd_d = mem_q[lat_q];
   end

   // Port state registers
   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
      begin
         lat_q     <= '0;
         sel_q     <= 1'b0;
         reg_sel_q <= 1'b0;
         rd_q      <= bytewide_port_pkg::REG_RESET;
      end
      else
      begin
         lat_q     <= lat_d;
         sel_q     <= sel_d;
         reg_sel_q <= reg_sel_d;
         rd_q      <= rd_d;
      end
   end

   // Array write; no reset so it maps to memory. A write repeats every
   // cycle while write enable stays low, so the last data wins.
   always_ff @(posedge clk_sys_in)
   begin
      if (wr_en && !is_reg(lat_q))
         mem_q[lat_q] <= d3_q;
   end

   // Register bytes write, one process per byte of the window
   genvar gi;
   generate
      for (gi = 0; gi < bytewide_port_pkg::REG_CNT; gi++)
      begin : g_reg
         always_ff @(posedge clk_sys_in)
         begin
            if (!rstn_in)
               regs_q[gi] <= bytewide_port_pkg::REG_RESET;
            else if (wr_en && is_reg(lat_q)
                     && reg_idx(lat_q) == 4'(gi))
               regs_q[gi] <= d3_q;
         end
      end
   endgenerate

   // Data pins: driven only on a read, floated otherwise; the value
   // comes from a flop one cycle behind lat_q, so if the enable rises in
   // the cycle sel_q sets, that first cycle drives the previous byte
   assign dq_out      = rd_q;
   assign dq_oe_out   = rd_en;
   assign reg_sel_out = reg_sel_q;

   // Interrupt: any enabled source; polarity chooses drive style
   assign irq_any     = |(irq_en_in & irq_event_in);
   assign irq_pin_out = irq_high_in ? irq_any : 1'b0;
   assign irq_oe_out  = irq_high_in ? 1'b1 : irq_any;

   // Assertions on the port behaviour
   hiz_oe_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (s2_q.oe_n && s3_q.oe_n) |-> !dq_oe_out)
      else $error("data driven with output enable high");
   addr_latch_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      ce_fall |=> (lat_q == $past(a3_q)))
      else $error("address not latched on select fall");
   addr_hold_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      !ce_fall |=> $stable(lat_q))
      else $error("address changed without select fall");
   standby_idle_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (s2_q.ce_n && s3_q.ce_n) |-> !dq_oe_out)
      else $error("access during standby");
   standby_write_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (s2_q.ce_n && s3_q.ce_n) |-> !wr_en)
      else $error("write during standby");
   read_drive_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (sel_q && !s2_q.ce_n && !s3_q.ce_n && s3_q.we_n && s2_q.we_n
       && !s2_q.oe_n && !s3_q.oe_n) |-> dq_oe_out)
      else $error("read not driven");
   wr_noread_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      wr_en |-> !dq_oe_out)
      else $error("driving during write");
   reg_write_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_en && is_reg(lat_q))
      |=> regs_q[$past(lat_q[3:0])] == $past(d3_q))
      else $error("register byte not stored");
   array_write_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_en && !is_reg(lat_q))
      |=> mem_q[$past(lat_q)] == $past(d3_q))
      else $error("array byte not stored");
   reg_decode_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      sel_q |-> reg_sel_out
                == (lat_q[bytewide_port_pkg::ADDR_W-1:4] == '1))
      else $error("register window decode wrong");
   irq_push_pull_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      irq_high_in |-> irq_oe_out && irq_pin_out == irq_any)
      else $error("push-pull interrupt wrong");
   irq_open_drain_a: assert property (
      @(posedge clk_sys_in) disable iff (!rstn_in)
      !irq_high_in |-> !irq_pin_out && irq_oe_out == irq_any)
      else $error("open-drain interrupt wrong");

   // Main scenarios: read, array write, register write, open-drain
   // interrupt and the select fall itself
   rd_c:  cover property (@(posedge clk_sys_in) rd_en);
   wr_c:  cover property (@(posedge clk_sys_in) wr_en && !is_reg(lat_q));
   rw_c:  cover property (@(posedge clk_sys_in) wr_en && is_reg(lat_q));
   irq_c: cover property (@(posedge clk_sys_in) irq_any && !irq_high_in);
   ce_c:  cover property (@(posedge clk_sys_in) ce_fall);
endmodule : bytewide_memory_host_port

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model
(
   // Clock
   input  wire logic        clk_sys_in,
   // Device answer
   input  wire logic [7:0]  rd_in,
   input  wire logic        rd_oe_in,
   // Host strobes, address and write data
   output logic             ce_n_out,
   output logic             we_n_out,
   output logic             oe_n_out,
   output logic [14:0]      addr_out,
   output logic [7:0]       dq_out
);
   initial {ce_n_out, we_n_out, oe_n_out, addr_out, dq_out} = 26'h3800000;
   // One byte access; ce_n returns high with recovery time after it
   task automatic acc(input logic [14:0] a, input logic sel, input logic wr,
                      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge clk_sys_in) #2;
      addr_out = a;
      ce_n_out = ~sel;
      repeat (5) @(posedge clk_sys_in) #2;
      addr_out = ~a;
      if (wr)
      begin
         dq_out = wd;
         we_n_out = 1'b0;
         repeat (6) @(posedge clk_sys_in) #2;
         we_n_out = 1'b1;
         dq_out = ~wd;                          // Released bus shows inverse
         rd = 8'h00;
      end
      else
      begin
         oe_n_out = 1'b0;
         while (rd_oe_in !== 1'b1 && n < 12)
         begin
            @(posedge clk_sys_in) #2;
            n++;
         end
         rd = (rd_oe_in === 1'b1) ? rd_in : 8'hxx;
         oe_n_out = 1'b1;
      end
      @(posedge clk_sys_in) #2;
      ce_n_out = 1'b1;
      repeat (6) @(posedge clk_sys_in);
   endtask : acc
endmodule : host_model

// ==== sim/bytewide_memory_host_port_tb.sv ====
`timescale 1ns/1ps
module bytewide_memory_host_port_tb;
   logic                        clk_sys_in = 1'b0;
   logic                        rstn_in = 1'b0;
   logic                        ce_n, we_n, oe_n, dq_oe, ipin, ioe, rsel;
   logic                        sel_q = 1'b0;
   logic [14:0]                 addr, a;
   logic [7:0]                  dq, rdata, rd, wd;
   logic [15:0]                 lfsr_q = 16'h4f8f;    // Seed 20367
   logic [7:0]                  exp_q [0:32767];      // Expected contents
   logic [14:0]                 adr_q [0:39];         // Addresses written
   logic [6:0]                  irq_q = 7'h00;        // {high, event, en}
   int                          error_cnt = 0, num_checks = 0, cyc = 0;
   initial forever #25 clk_sys_in = ~clk_sys_in;
   host_model host (.clk_sys_in(clk_sys_in), .rd_in(rdata), .rd_oe_in(dq_oe),
      .ce_n_out(ce_n), .we_n_out(we_n), .oe_n_out(oe_n), .addr_out(addr),
      .dq_out(dq));
   bytewide_memory_host_port uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(addr),
      .dq_in(dq), .dq_out(rdata), .dq_oe_out(dq_oe),
      .irq_en_in(irq_q[2:0]), .irq_event_in(irq_q[5:3]),
      .irq_high_in(irq_q[6]), .irq_pin_out(ipin), .irq_oe_out(ioe),
      .reg_sel_out(rsel));
   // Remember the decode seen while the device drives the bus; taken on
   // the falling edge so it never races the launching clock edge
   always @(negedge clk_sys_in)
   begin
      if (dq_oe === 1'b1) sel_q <= rsel;
   end
   // Cycle ceiling: a hang counts as a mismatch and ends the run
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt
   // Expected {enable, pin}; pin only matters while enabled
   function automatic logic [7:0] irq_exp(input logic [6:0] k);
      return k[6] ? {6'h0, 1'b1, |(k[2:0] & k[5:3])}
                  : {6'h0, |(k[2:0] & k[5:3]), 1'b0};
   endfunction : irq_exp
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // Read every register byte back and expect its reset value
   task automatic reg_scan();
      logic [7:0] r;
      for (int i = 0; i < 16; i++)
      begin
         host.acc(15'h7ff0 + 15'(i), 1'b1, 1'b0, 8'h00, r);
         chk(r, 8'h00);
      end
   endtask : reg_scan
   initial
   begin
      repeat (3) @(posedge clk_sys_in) #2;
      rstn_in = 1'b1;
      reg_scan();
      for (int i = 0; i < 40; i++)
      begin
         lfsr_q = nxt(lfsr_q);
         a = (i < 4) ? 15'h7fef + 15'(i * 4) : lfsr_q[14:0];
         wd = lfsr_q[7:0] ^ lfsr_q[15:8];
         host.acc(a, 1'b1, 1'b1, wd, rd);
         exp_q[a] = wd;
         adr_q[i] = a;
         host.acc(a, 1'b0, 1'b1, ~wd, rd);
         host.acc(a, 1'b1, 1'b0, 8'h00, rd);
         chk(rd, wd);
         chk({7'h0, sel_q}, {7'h0, a >= 15'h7ff0});
         chk({7'h0, dq_oe}, 8'h00);
      end
      for (int k = 0; k < 40; k++)
      begin
         host.acc(adr_q[k], 1'b1, 1'b0, 8'h00, rd);
         chk(rd, exp_q[adr_q[k]]);
      end
      // Reset in mid-run: register bytes return to their reset value
      @(posedge clk_sys_in) #2;
      rstn_in = 1'b0;
      repeat (3) @(posedge clk_sys_in) #2;
      rstn_in = 1'b1;
      reg_scan();
      for (int k = 0; k < 128; k++)
      begin
         @(posedge clk_sys_in) #2;
         irq_q = 7'(k);
         #1 chk({6'h0, ioe, ipin & ioe}, irq_exp(irq_q));
      end
      print_verdict();
   end
endmodule : bytewide_memory_host_port_tb
